//--- rtl/cimb_mask_bank.sv
// charger interrupt mask registers with flag recording and interrupt pulse
`timescale 1ns/10ps

module cimb_mask_bank (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // register port
    input  wire cimb_pkg::cimb_addr_t reg_addr,
    input  wire logic               reg_wr,
    input  wire cimb_pkg::cimb_byte_t reg_wdata,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // event pulses from the charger logic
    input  wire cimb_pkg::cimb_byte_t charger_events,
    input  wire cimb_pkg::cimb_byte_t fault_events,
    input  wire cimb_pkg::cimb_byte_t therm_events,
    // interrupt towards the host
    output logic                    irq,
    // individual mask gates for neighbouring logic
    output logic                    const_voltage_phase_gate,
    output logic                    charge_done_gate,
    output logic                    input_current_limit_gate,
    output logic                    power_path_limit_gate,
    output logic                    input_voltage_limit_gate,
    output logic                    thermal_regulation_gate,
    output logic                    input_power_good_gate,
    output logic                    input_overvoltage_gate,
    output logic                    battery_overcurrent_gate,
    output logic                    battery_undervoltage_gate,
    output logic                    therm_cold_region_gate,
    output logic                    therm_cool_region_gate,
    output logic                    therm_warm_region_gate,
    output logic                    therm_hot_region_gate,
    output logic                    thermistor_open_gate
);
    import cimb_pkg::*;

    // select one byte group out of a 24-bit vector
    function automatic cimb_byte_t grp_byte(input cimb_evt_t vec, input int grp);
        grp_byte = vec[grp*DATA_W +: DATA_W];
    endfunction

    // address match helper used by write and clear decode
    function automatic logic hit(input cimb_addr_t a, input cimb_addr_t ofs);
        hit = (a == ofs);
    endfunction

    cimb_flag_if flg ();

    cimb_flag_bank u_flags (
        .clk_sys (clk_sys),
        .rst     (rst),
        .flg     (flg)
    );

    // mask registers
    cimb_byte_t             chg_mask_q;
    cimb_byte_t             chg_mask_d;
    cimb_byte_t             flt_mask_q;
    cimb_byte_t             flt_mask_d;
    cimb_byte_t             thm_mask_q;
    cimb_byte_t             thm_mask_d;

    // read data and interrupt
    cimb_byte_t             rdata_q;
    cimb_byte_t             rdata_d;
    logic                   irq_q;
    logic                   irq_d;

    cimb_evt_t              events;
    cimb_evt_t              mask_vec;
    logic [NUM_GROUPS-1:0]  rd_clr;

    // events gathered in group order
    assign events = {therm_events, fault_events, charger_events};
    assign mask_vec = {thm_mask_q, flt_mask_q, chg_mask_q};

    // every event except thermistor bits 7:4 reaches its flag regardless of the masks
    assign flg.set_evt = events;

    // a read of a flag register clears that group
    always_comb begin
        rd_clr = '0;
        if (reg_rd) begin
            rd_clr[GRP_CHG] = hit(reg_addr, OFS_CHG_FLAG);
            rd_clr[GRP_FLT] = hit(reg_addr, OFS_FLT_FLAG);
            rd_clr[GRP_THM] = hit(reg_addr, OFS_THM_FLAG);
        end
    end

    assign flg.rd_clr = rd_clr;

    // next mask values from register writes
    always_comb begin
        chg_mask_d = chg_mask_q;
        flt_mask_d = flt_mask_q;
        thm_mask_d = thm_mask_q;
        if (reg_wr) begin
            if (hit(reg_addr, OFS_CHG_MASK)) begin
                chg_mask_d = reg_wdata;
            end
            if (hit(reg_addr, OFS_FLT_MASK)) begin
                flt_mask_d = reg_wdata;
            end
            if (hit(reg_addr, OFS_THM_MASK)) begin
                // upper bits hold their fixed value
                thm_mask_d = (reg_wdata & THM_MASK_WR) | THM_MASK_RO;
            end
        end
    end

    // mask storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chg_mask_q <= RST_CHG_MASK;
            flt_mask_q <= RST_FLT_MASK;
            thm_mask_q <= RST_THM_MASK;
        end else begin
            chg_mask_q <= chg_mask_d;
            flt_mask_q <= flt_mask_d;
            thm_mask_q <= thm_mask_d;
        end
    end

    // read multiplexer, value before any clear of this cycle
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CHG_FLAG: begin
                    rdata_d = grp_byte(flg.flags, GRP_CHG);
                end
                OFS_FLT_FLAG: begin
                    rdata_d = grp_byte(flg.flags, GRP_FLT);
                end
                OFS_THM_FLAG: begin
                    rdata_d = grp_byte(flg.flags, GRP_THM);
                end
                OFS_CHG_MASK: begin
                    rdata_d = chg_mask_q;
                end
                OFS_FLT_MASK: begin
                    rdata_d = flt_mask_q;
                end
                OFS_THM_MASK: begin
                    rdata_d = thm_mask_q;
                end
                default: begin
                    rdata_d = READ_NONE;
                end
            endcase
        end
    end

    // interrupt: one pulse when an unmasked event arrives
    always_comb begin
        irq_d = |(events & ~mask_vec);
    end

    // read data and interrupt registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= READ_NONE;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = irq_q;

    // charger gates, 1 means suppressed
    assign const_voltage_phase_gate  = chg_mask_q[BIT_CV_PHASE];
    assign charge_done_gate          = chg_mask_q[BIT_CHG_DONE];
    assign input_current_limit_gate  = chg_mask_q[BIT_IIN_LIMIT];
    assign power_path_limit_gate     = chg_mask_q[BIT_PWR_PATH];
    assign input_voltage_limit_gate  = chg_mask_q[BIT_VIN_LIMIT];
    assign thermal_regulation_gate   = chg_mask_q[BIT_THERM_REG];
    assign input_power_good_gate     = chg_mask_q[BIT_PWR_GOOD];

    // fault gates
    assign input_overvoltage_gate    = flt_mask_q[BIT_VIN_OVP];
    assign battery_overcurrent_gate  = flt_mask_q[BIT_BAT_OCP];
    assign battery_undervoltage_gate = flt_mask_q[BIT_BAT_UV];
    assign therm_cold_region_gate    = flt_mask_q[BIT_TS_COLD];
    assign therm_cool_region_gate    = flt_mask_q[BIT_TS_COOL];
    assign therm_warm_region_gate    = flt_mask_q[BIT_TS_WARM];
    assign therm_hot_region_gate     = flt_mask_q[BIT_TS_HOT];

    // thermistor gate
    assign thermistor_open_gate      = thm_mask_q[BIT_TS_OPEN];

endmodule // cimb_mask_bank

//--- rtl/cimb_pkg.sv
// constants of the charger interrupt mask bank
package cimb_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int EVT_W  = 24;
    localparam int NUM_GROUPS = 3;

    typedef logic [ADDR_W-1:0] cimb_addr_t;
    typedef logic [DATA_W-1:0] cimb_byte_t;
    typedef logic [EVT_W-1:0]  cimb_evt_t;

    // register offsets
    localparam cimb_addr_t OFS_CHG_FLAG = 8'h03;
    localparam cimb_addr_t OFS_FLT_FLAG = 8'h04;
    localparam cimb_addr_t OFS_THM_FLAG = 8'h05;
    localparam cimb_addr_t OFS_CHG_MASK = 8'h07;
    localparam cimb_addr_t OFS_FLT_MASK = 8'h08;
    localparam cimb_addr_t OFS_THM_MASK = 8'h09;

    // reset values
    localparam cimb_byte_t RST_CHG_MASK = 8'h00;
    localparam cimb_byte_t RST_FLT_MASK = 8'h00;
    localparam cimb_byte_t RST_THM_MASK = 8'h71;
    localparam cimb_byte_t RST_FLAG     = 8'h00;
    localparam cimb_byte_t READ_NONE    = 8'h00;

    // thermistor mask: writable low nibble, fixed read-only upper bits
    localparam cimb_byte_t THM_MASK_WR  = 8'h0F;
    localparam cimb_byte_t THM_MASK_RO  = 8'h70;
    // thermistor flag: bits above the low nibble are not stored
    localparam cimb_byte_t THM_FLAG_KEEP = 8'h0F;

    // group index inside the 24-bit event and flag vectors
    localparam int GRP_CHG = 0;
    localparam int GRP_FLT = 1;
    localparam int GRP_THM = 2;

    // charger group bit positions
    localparam int BIT_CHG_RSVD    = 7;
    localparam int BIT_CV_PHASE    = 6;
    localparam int BIT_CHG_DONE    = 5;
    localparam int BIT_IIN_LIMIT   = 4;
    localparam int BIT_PWR_PATH    = 3;
    localparam int BIT_VIN_LIMIT   = 2;
    localparam int BIT_THERM_REG   = 1;
    localparam int BIT_PWR_GOOD    = 0;

    // fault group bit positions
    localparam int BIT_VIN_OVP     = 7;
    localparam int BIT_FLT_RSVD    = 6;
    localparam int BIT_BAT_OCP     = 5;
    localparam int BIT_BAT_UV      = 4;
    localparam int BIT_TS_COLD     = 3;
    localparam int BIT_TS_COOL     = 2;
    localparam int BIT_TS_WARM     = 1;
    localparam int BIT_TS_HOT      = 0;

    // thermistor group bit positions
    localparam int BIT_TS_OPEN     = 0;

endpackage

//--- rtl/cimb_flag_if.sv
// carrier between the mask bank and its event flag bank
`timescale 1ns/10ps
interface cimb_flag_if;
    import cimb_pkg::*;

    cimb_evt_t                  set_evt;   // one-cycle event pulses
    logic [NUM_GROUPS-1:0]      rd_clr;    // clear-on-read per group
    cimb_evt_t                  flags;     // recorded flags

    modport bank  (input set_evt, input rd_clr, output flags);
    modport owner (output set_evt, output rd_clr, input flags);
endinterface

//--- rtl/cimb_flag_bank.sv
// sticky event flags that clear when read
`timescale 1ns/10ps
module cimb_flag_bank (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    cimb_flag_if.bank   flg
);
    import cimb_pkg::*;

    cimb_evt_t flags_q;
    cimb_evt_t flags_d;
    cimb_evt_t keep_mask;

    // group keep pattern: thermistor upper bits are never stored
    assign keep_mask = {THM_FLAG_KEEP, {DATA_W{1'b1}}, {DATA_W{1'b1}}};

    // next flags: clear on read, a new event wins over the clear
    always_comb begin
        flags_d = flags_q;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (flg.rd_clr[g]) begin
                flags_d[g*DATA_W +: DATA_W] = RST_FLAG;
            end
        end
        flags_d = (flags_d | flg.set_evt) & keep_mask;
    end

    // flag storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_q <= {NUM_GROUPS{RST_FLAG}};
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flg.flags = flags_q;

endmodule // cimb_flag_bank

//--- sim/cimb_host_model.sv
// host side of the register port, standing in for the serial slave's internal side
`timescale 1ns/10ps
module cimb_host_model (
    input  wire logic           clk_sys,
    output cimb_pkg::cimb_addr_t reg_addr,
    output logic                reg_wr,
    output cimb_pkg::cimb_byte_t reg_wdata,
    output logic                reg_rd
);
    import cimb_pkg::*;
    // idle bus at time zero
    initial begin
        reg_addr = 8'hFF;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // one strobe cycle, then release with inverted address and data
    task automatic xfer(input logic w, input cimb_addr_t a, input cimb_byte_t d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // cimb_host_model

//--- sim/cimb_mask_bank_properties.sv
// port assertions for the charger interrupt mask bank
`timescale 1ns/10ps
module cimb_props (
    input wire logic clk_sys, input wire logic rst,
    input wire cimb_pkg::cimb_addr_t reg_addr, input wire logic reg_wr,
    input wire cimb_pkg::cimb_byte_t reg_wdata, input wire logic reg_rd,
    input wire logic [7:0] reg_rdata, input wire cimb_pkg::cimb_byte_t charger_events,
    input wire cimb_pkg::cimb_byte_t fault_events, input wire cimb_pkg::cimb_byte_t therm_events,
    input wire logic irq, input wire logic const_voltage_phase_gate, input wire logic charge_done_gate,
    input wire logic input_current_limit_gate, input wire logic power_path_limit_gate,
    input wire logic input_voltage_limit_gate, input wire logic thermal_regulation_gate,
    input wire logic input_power_good_gate, input wire logic input_overvoltage_gate,
    input wire logic battery_overcurrent_gate, input wire logic battery_undervoltage_gate,
    input wire logic therm_cold_region_gate, input wire logic therm_cool_region_gate,
    input wire logic therm_warm_region_gate, input wire logic therm_hot_region_gate,
    input wire logic thermistor_open_gate
);
    import cimb_pkg::*;
    // gate groups and interrupt causes
    wire [6:0] chg_g = {const_voltage_phase_gate, charge_done_gate, input_current_limit_gate,
        power_path_limit_gate, input_voltage_limit_gate, thermal_regulation_gate, input_power_good_gate};
    wire [6:0] flt_g = {input_overvoltage_gate, battery_overcurrent_gate, battery_undervoltage_gate,
        therm_cold_region_gate, therm_cool_region_gate, therm_warm_region_gate, therm_hot_region_gate};
    wire [6:0] wd_flt = {reg_wdata[7], reg_wdata[5:0]};
    wire vis = |(charger_events[6:0] & ~chg_g) | |({fault_events[7], fault_events[5:0]} & ~flt_g)
        | (therm_events[0] & ~thermistor_open_gate);
    wire cause = vis | charger_events[7] | fault_events[6] | (|therm_events[3:1]);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_unmasked; vis; endsequence
    sequence s_irq_next; ##1 irq; endsequence
    property p_rst_vals; $fell(rst) |-> chg_g == 7'h00 && flt_g == 7'h00 && thermistor_open_gate; endproperty
    property p_chg_wr; reg_wr && reg_addr == 8'h07 |=> chg_g == $past(reg_wdata[6:0]); endproperty
    property p_flt_wr; reg_wr && reg_addr == 8'h08 |=> flt_g == $past(wd_flt); endproperty
    property p_thm_wr; reg_wr && reg_addr == 8'h09 |=> thermistor_open_gate == $past(reg_wdata[0]); endproperty
    property p_gate_hold; !reg_wr |=> $stable(chg_g) && $stable(flt_g) && $stable(thermistor_open_gate); endproperty
    property p_irq_fire; s_unmasked |-> s_irq_next; endproperty
    property p_irq_cause; irq |-> $past(cause); endproperty
    property p_rd_thm; reg_rd && reg_addr == 8'h09 |=> reg_rdata[7:4] == 4'h7; endproperty
    property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    property p_rd_chg; reg_rd && reg_addr == 8'h07 |=> reg_rdata[6:0] == $past(chg_g); endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("mask gates wrong after reset");
    a_chg_wr: assert property (p_chg_wr)
        else $error("charger gates do not follow write");
    a_flt_wr: assert property (p_flt_wr)
        else $error("fault gates do not follow write");
    a_thm_wr: assert property (p_thm_wr)
        else $error("thermistor open gate does not follow write");
    a_gate_hold: assert property (p_gate_hold)
        else $error("gate changed without write");
    a_irq_fire: assert property (p_irq_fire)
        else $error("unmasked event gave no interrupt");
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without unmasked event");
    a_rd_thm: assert property (p_rd_thm)
        else $error("thermistor mask upper bits wrong");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read");
    a_rd_chg: assert property (p_rd_chg)
        else $error("charger mask read differs from gates");
endmodule // cimb_props
bind cimb_mask_bank cimb_props u_props (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .charger_events, .fault_events, .therm_events, .irq, .const_voltage_phase_gate,
    .charge_done_gate, .input_current_limit_gate, .power_path_limit_gate, .input_voltage_limit_gate,
    .thermal_regulation_gate, .input_power_good_gate, .input_overvoltage_gate, .battery_overcurrent_gate,
    .battery_undervoltage_gate, .therm_cold_region_gate, .therm_cool_region_gate,
    .therm_warm_region_gate, .therm_hot_region_gate, .thermistor_open_gate);

//--- sim/testbench.sv
// self-checking bench for the charger interrupt mask bank
`timescale 1ns/10ps
module testbench;
    import cimb_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, irq, rd_pend;
    cimb_addr_t reg_addr;
    cimb_byte_t reg_wdata, charger_events, fault_events, therm_events, d, ev;
    logic [7:0] reg_rdata;
    cimb_byte_t exp_q[$];
    int num_errors, samples_checked;
    int unsigned seed;
    localparam cimb_addr_t MOFS [3] = '{8'h07, 8'h08, 8'h09};
    localparam cimb_addr_t FOFS [3] = '{OFS_CHG_FLAG, OFS_FLT_FLAG, OFS_THM_FLAG};
    cimb_mask_bank DUT (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .charger_events, .fault_events, .therm_events, .irq, .const_voltage_phase_gate(),
        .charge_done_gate(), .input_current_limit_gate(), .power_path_limit_gate(),
        .input_voltage_limit_gate(), .thermal_regulation_gate(), .input_power_good_gate(),
        .input_overvoltage_gate(), .battery_overcurrent_gate(), .battery_undervoltage_gate(),
        .therm_cold_region_gate(), .therm_cool_region_gate(), .therm_warm_region_gate(),
        .therm_hot_region_gate(), .thermistor_open_gate());
    cimb_host_model host (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rd(input cimb_addr_t a, input cimb_byte_t e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic rd_resets();
        rd(MOFS[0], 8'h00);
        rd(MOFS[1], 8'h00);
        rd(MOFS[2], 8'h71);
        rd(8'h00, 8'h00);
    endtask
    // read data lands on its strobe edge and is checked on the next falling edge
    always @(posedge clk_sys) rd_pend <= reg_rd && !rst;
    always @(negedge clk_sys) begin
        if (rd_pend) check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    // hang guard
    initial begin
        #400000;
        num_errors++;
        test_done();
    end
    // main sequence
    initial begin
        num_errors = 0;
        samples_checked = 0;
        rd_pend = 1'b0;
        {therm_events, fault_events, charger_events} = 24'h000000;
        rst = 1'b1;
        seed = $urandom(25259);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        rd_resets();
        // flag registers ignore writes
        host.xfer(1'b1, OFS_FLT_FLAG, 8'hFF);
        rd(OFS_FLT_FLAG, 8'h00);
        for (int g = 0; g < 3; g++) begin
            d = 8'($urandom());
            host.xfer(1'b1, MOFS[g], d);
            rd(MOFS[g], (g == 2) ? {4'h7, d[3:0]} : d);
        end
        // each charger, fault and thermistor open event under a random mask
        for (int i = 0; i < 17; i++) begin
            d = 8'($urandom());
            host.xfer(1'b1, MOFS[i / 8], d);
            ev = 8'h01 << (i % 8);
            {therm_events, fault_events, charger_events} = 24'h000001 << i;
            @(negedge clk_sys);
            {therm_events, fault_events, charger_events} = 24'h000000;
            check("irq", {7'h00, irq}, {7'h00, ~d[i % 8]});
            rd(FOFS[i / 8], ev);
            rd(FOFS[i / 8], 8'h00);
        end
        // second reset mid-run, after the last read result is checked
        @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys) rst = 1'b0;
        rd_resets();
        repeat (2) @(negedge clk_sys);
        test_done();
    end
endmodule // testbench
